/* rtl/sfm_regs.vh */
// Register map, field positions, reset values and timing constants of the fault monitor timing block.
//
// Operation
// - Red-fail timeout is 1350 ms with its switch on, 850 ms with it off.
// - Watchdog timeout is 1.0 s with its switch on, 1.5 s off.
// - Brown-out setting on applies a brown-out timing value of 400.
// - Watchdog latch off clears a watchdog fault after power loss or brown-out.
// - Relay common sense is active high, inverted when polarity reversal is set.
// - Removed red interface cable raises a latching fault and forces flash.
// - Any active inhibit input suspends red-fail monitoring only.
// - Inhibit input active after 550 ms asserted, inactive below 250 ms.
// - Red input on after 500 ms asserted, off below 200 ms.
// - Green or yellow input on after 500 ms, off below 200 ms.
// - Any fault is held until front-panel, remote or software reset, save a watchdog fault with its latch off.
// - No indication beyond the selected timeout trips red failure and flash.
// - Absence shorter than 350 ms or 850 ms never trips red failure; counting the 500 ms requalification, absence over 350 ms or 850 ms trips.
// - Red-fail monitoring is enabled per channel by a switch.
// - Red-fail monitoring runs only with gate active and no inhibit active.
// - Drive red, yellow and green indicators for 18 channels, 54 outputs.
// - Fault indications and channel status are frozen until reset.
`ifndef SFM_REGS_VH
`define SFM_REGS_VH

`define SFM_CLK_HZ 40000000
// Millisecond to cycle conversion.
`define SFM_MS(x) ((x) * (`SFM_CLK_HZ / 1000))

`define SFM_RF_LONG_MS 1350
`define SFM_RF_SHORT_MS 850
`define SFM_WD_LONG_MS 1500
`define SFM_WD_SHORT_MS 1000
`define SFM_BO_ON_VAL 400
`define SFM_BO_OFF_VAL 0
`define SFM_INH_ON_MS 550
`define SFM_FLD_ON_MS 500

// APB byte offsets.
`define SFM_A_STATUS 12'h000
`define SFM_A_MASK 12'h004
`define SFM_A_CTRL 12'h008
`define SFM_A_RFEN 12'h00C
`define SFM_A_FAULT 12'h010
`define SFM_A_RED 12'h014
`define SFM_A_YEL 12'h018
`define SFM_A_GRN 12'h01C
`define SFM_A_BOVAL 12'h020

// Status and fault bits.
`define SFM_B_REDFAIL 0
`define SFM_B_WDT 1
`define SFM_B_CABLE 2
`define SFM_B_BROWN 3

// Control bits.
`define SFM_C_RFLONG 0
`define SFM_C_WDLONG 1
`define SFM_C_BOSET 2
`define SFM_C_WDLATCH 3
`define SFM_C_POLREV 4
`define SFM_C_RESET 5

`define SFM_RST_MASK 4'h0
`define SFM_RST_CTRL 5'h03
`define SFM_RST_RFEN 18'h3FFFF

`endif

/* rtl/sfm_monitor.v */
// Fault timing core of an 18-channel signal monitor with its APB register file.
//
// The address map and register access over APB were left to the implementer.
`timescale 1ns/10ps
`default_nettype none
`include "sfm_regs.vh"

module sfm_monitor #(
    parameter NCH = 18,
    parameter RF_LONG_CYC = `SFM_MS(`SFM_RF_LONG_MS),
    parameter RF_SHORT_CYC = `SFM_MS(`SFM_RF_SHORT_MS),
    parameter WD_LONG_CYC = `SFM_MS(`SFM_WD_LONG_MS),
    parameter WD_SHORT_CYC = `SFM_MS(`SFM_WD_SHORT_MS),
    parameter INH_CYC = `SFM_MS(`SFM_INH_ON_MS),
    parameter FLD_CYC = `SFM_MS(`SFM_FLD_ON_MS)
) (
    input wire clk_sys,
    input wire rst,
    input wire psel,
    input wire penable,
    input wire pwrite,
    input wire [11:0] paddr,
    input wire [31:0] pwdata,
    output wire pready,
    output reg [31:0] prdata,
    output wire pslverr,
    input wire [NCH-1:0] red_in,
    input wire [NCH-1:0] yel_in,
    input wire [NCH-1:0] grn_in,
    input wire inhibit1_in,
    input wire inhibit2_in,
    input wire red_gate_in,
    input wire relay_common_sense,
    input wire red_interface_cable,
    input wire watchdog_in,
    input wire power_fail_in,
    input wire front_reset_in,
    input wire remote_reset_in,
    output wire irq,
    output reg fault_r,
    output reg flash_r,
    output reg relay_common_act_r,
    output reg [NCH-1:0] red_led_r,
    output reg [NCH-1:0] yel_led_r,
    output reg [NCH-1:0] grn_led_r
);

    // ------------------------------------------------------------------
    // Behaviour overview
    // ------------------------------------------------------------------
    // Every field, inhibit and gate pin is asynchronous to clk_sys, so all of
    // them pass a two-stage synchroniser before any logic reads them.
    // Each synchronised lamp, inhibit and gate input then goes through a
    // duration qualifier. A qualifier turns on only after an unbroken run of
    // high cycles and turns off at the first low cycle. A short pulse
    // therefore never qualifies. A high run that ends before the on limit
    // leaves the qualifier off, and so does any low cycle.
    // The red failure timer runs per channel while its enable bit is set,
    // the gate is qualified, no inhibit is qualified and the channel shows
    // no qualified colour at all. Any qualified colour restarts it.
    // The watchdog timer restarts on every toggle of the watchdog pin and
    // trips when the pin stays still for the selected limit.
    // All fault events feed one latch. Only the front-panel reset pin, the
    // remote reset pin or the software reset bit clear it, except that power
    // fail also clears the watchdog bit while wd_latch is off, and an event
    // that is still present sets it again in the same cycle.
    // The flash output follows the latch, so the cabinet stays in flash
    // for as long as any fault is held.
    // The indicator outputs follow the qualified colours while no fault is
    // held and freeze at the first fault. That keeps the channel picture
    // of the moment of failure visible until the monitor is reset.
    // Status bits are sticky and only record newly latched faults, so a
    // fault that stays latched raises the interrupt once and not again.
    // The bus side answers every access at once: pready is tied high and
    // read data is loaded in the setup cycle.
    // Limitation: all timing counts assume the clock at its nominal rate;
    // a slower clock stretches every timeout by the same ratio.

    // ------------------------------------------------------------------
    // Input synchronisers
    // ------------------------------------------------------------------
    localparam NIN = 3 * NCH + 9;
    wire [NIN-1:0] raw_in = {red_in, yel_in, grn_in, inhibit1_in, inhibit2_in, red_gate_in,
        relay_common_sense, red_interface_cable, watchdog_in, power_fail_in, front_reset_in,
        remote_reset_in};
    reg [NIN-1:0] sync1_r;
    reg [NIN-1:0] sync2_r;
    // Reset values are the idle levels of the pins. The cable pin idles high;
    // clearing its stages to zero would latch a false cable fault after reset.
    localparam [NIN-1:0] SYNC_IDLE = {{(NIN-5){1'b0}}, 1'b1, 4'h0};
    always @(posedge clk_sys) begin
        if (rst) begin
            sync1_r <= SYNC_IDLE;
            sync2_r <= SYNC_IDLE;
        end else begin
            sync1_r <= raw_in;
            sync2_r <= sync1_r;
        end
    end
    wire [NCH-1:0] red_s = sync2_r[NIN-1 -: NCH];
    wire [NCH-1:0] yel_s = sync2_r[2*NCH+8 -: NCH];
    wire [NCH-1:0] grn_s = sync2_r[NCH+8 -: NCH];
    wire inh1_s = sync2_r[8];
    wire inh2_s = sync2_r[7];
    wire gate_s = sync2_r[6];
    wire rcs_s = sync2_r[5];
    wire cable_s = sync2_r[4];
    wire wd_s = sync2_r[3];
    wire pwr_s = sync2_r[2];
    wire frst_s = sync2_r[1];
    wire rrst_s = sync2_r[0];

    // ------------------------------------------------------------------
    // Duration qualification
    // ------------------------------------------------------------------
    // A qualifier goes on after on_cyc continuous cycles high and off at the first
    // low cycle. Any short pulse therefore never qualifies, and a high run in the undefined band
    // leaves the qualifier off, since every low cycle restarts the count.
    localparam NQ = 3 * NCH + 3;
    localparam QW = 26;
    wire [NQ-1:0] q_raw = {red_s, yel_s, grn_s, inh1_s, inh2_s, gate_s};
    reg [QW-1:0] q_cnt_r [0:NQ-1];
    reg [NQ-1:0] q_on_r;
    integer i;
    always @(posedge clk_sys) begin
        for (i = 0; i < NQ; i = i + 1) begin
            if (rst || !q_raw[i]) begin
                q_cnt_r[i] <= {QW{1'b0}};
                q_on_r[i] <= 1'b0;
            end else if (q_cnt_r[i] >= ((i < 3) ? INH_CYC[QW-1:0] : FLD_CYC[QW-1:0]) - 1) begin
                q_on_r[i] <= 1'b1;
            end else begin
                q_cnt_r[i] <= q_cnt_r[i] + 1'b1;
            end
        end
    end
    wire [NCH-1:0] red_q = q_on_r[NQ-1 -: NCH];
    wire [NCH-1:0] yel_q = q_on_r[2*NCH+2 -: NCH];
    wire [NCH-1:0] grn_q = q_on_r[NCH+2 -: NCH];
    wire inhibit_q = q_on_r[2] | q_on_r[1];
    wire gate_q = q_on_r[0];

    // ------------------------------------------------------------------
    // Helper functions
    // ------------------------------------------------------------------
    // Zero-extends a per-channel word to the bus width.
    function [31:0] pad_ch;
        input [NCH-1:0] v;
        begin
            pad_ch = {{(32-NCH){1'b0}}, v};
        end
    endfunction

    // Zero-extends a four-bit fault word to the bus width.
    function [31:0] pad_flt;
        input [3:0] v;
        begin
            pad_flt = {28'h0000000, v};
        end
    endfunction

    // True for every implemented register offset; all others answer with an error.
    function is_mapped;
        input [11:0] a;
        begin
            case (a)
                `SFM_A_STATUS, `SFM_A_MASK, `SFM_A_CTRL, `SFM_A_RFEN, `SFM_A_FAULT,
                `SFM_A_RED, `SFM_A_YEL, `SFM_A_GRN, `SFM_A_BOVAL: is_mapped = 1'b1;
                default: is_mapped = 1'b0;
            endcase
        end
    endfunction

    // ------------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------------
    reg [3:0] status_r;
    reg [3:0] mask_r;
    reg [4:0] ctrl_r;
    reg [NCH-1:0] rf_en_r;
    reg [3:0] fault_bits_r;
    reg soft_reset_r;

    wire wr = psel && penable && pwrite;
    // Writes land in the access phase only; a write to an unmapped offset is
    // dropped and flagged through pslverr.
    wire rd_ok = is_mapped(paddr);
    assign pready = 1'b1;
    assign pslverr = psel && penable && !rd_ok;

    wire rf_long = ctrl_r[`SFM_C_RFLONG];
    wire wd_long = ctrl_r[`SFM_C_WDLONG];
    wire bo_set = ctrl_r[`SFM_C_BOSET];
    wire wd_latch = ctrl_r[`SFM_C_WDLATCH];
    wire pol_rev = ctrl_r[`SFM_C_POLREV];

    // ------------------------------------------------------------------
    // Red failure timing
    // ------------------------------------------------------------------
    // The timer is held at zero whenever monitoring is suspended, so a
    // suspension always restarts the full timeout instead of resuming it.
    // Inhibits stop only this timer; every other fault source keeps running.
    wire rf_run = gate_q && !inhibit_q;
    wire [QW-1:0] rf_lim = rf_long ? RF_LONG_CYC[QW-1:0] : RF_SHORT_CYC[QW-1:0];
    reg [QW-1:0] rf_cnt_r [0:NCH-1];
    reg [NCH-1:0] rf_trip;
    // A loop variable of its own keeps this process from sharing one with the qualifiers.
    integer j;
    always @(posedge clk_sys) begin
        for (j = 0; j < NCH; j = j + 1) begin
            if (rst || !rf_run || !rf_en_r[j] || red_q[j] || yel_q[j] || grn_q[j]) begin
                rf_cnt_r[j] <= {QW{1'b0}};
                rf_trip[j] <= 1'b0;
            end else if (rf_cnt_r[j] >= rf_lim) begin
                rf_trip[j] <= 1'b1;
            end else begin
                rf_cnt_r[j] <= rf_cnt_r[j] + 1'b1;
            end
        end
    end

    // ------------------------------------------------------------------
    // Watchdog timing
    // ------------------------------------------------------------------
    // Brown-out faults come from the power-fail input; its analog timing value is
    // only reported to software, since the measurement itself lies outside.
    wire [QW-1:0] wd_lim = wd_long ? WD_SHORT_CYC[QW-1:0] : WD_LONG_CYC[QW-1:0];
    reg [QW-1:0] wd_cnt_r;
    reg wd_prev_r;
    reg wd_trip;
    always @(posedge clk_sys) begin
        wd_prev_r <= rst ? 1'b0 : wd_s;
        if (rst || (wd_s != wd_prev_r) || pwr_s) begin
            wd_cnt_r <= {QW{1'b0}};
            wd_trip <= 1'b0;
        end else if (wd_cnt_r >= wd_lim) begin
            wd_trip <= 1'b1;
        end else begin
            wd_cnt_r <= wd_cnt_r + 1'b1;
        end
    end

    // ------------------------------------------------------------------
    // Fault latch
    // ------------------------------------------------------------------
    // The reset pins are levels: while one is held the latch stays clear
    // except for events that are still present, which set it again at once.
    wire clr = frst_s || rrst_s || soft_reset_r;
    wire [3:0] ev;
    assign ev[`SFM_B_REDFAIL] = |rf_trip;
    assign ev[`SFM_B_WDT] = wd_trip;
    assign ev[`SFM_B_CABLE] = !cable_s;
    assign ev[`SFM_B_BROWN] = pwr_s;
    reg [3:0] fault_nxt;
    always @* begin
        fault_nxt = clr ? 4'h0 : fault_bits_r;
        if (!wd_latch && pwr_s) begin
            fault_nxt[`SFM_B_WDT] = 1'b0;
        end
        fault_nxt = fault_nxt | ev;
    end
    always @(posedge clk_sys) begin
        if (rst) begin
            fault_bits_r <= 4'h0;
            fault_r <= 1'b0;
            flash_r <= 1'b0;
            relay_common_act_r <= 1'b0;
            red_led_r <= {NCH{1'b0}};
            yel_led_r <= {NCH{1'b0}};
            grn_led_r <= {NCH{1'b0}};
        end else begin
            fault_bits_r <= fault_nxt;
            fault_r <= |fault_nxt;
            flash_r <= |fault_nxt;
            // The reversal bit flips the sense for fail-safe wiring of the common.
            relay_common_act_r <= rcs_s ^ pol_rev;
            if (!(|fault_bits_r)) begin
                red_led_r <= red_q;
                yel_led_r <= yel_q;
                grn_led_r <= grn_q;
            end
        end
    end

    // ------------------------------------------------------------------
    // APB register file and interrupt
    // ------------------------------------------------------------------
    always @(posedge clk_sys) begin
        if (rst) begin
            status_r <= 4'h0;
            mask_r <= `SFM_RST_MASK;
            ctrl_r <= `SFM_RST_CTRL;
            rf_en_r <= `SFM_RST_RFEN;
            soft_reset_r <= 1'b0;
        end else begin
            // The reset bit is a one-cycle pulse and is never stored in the control word.
            soft_reset_r <= wr && (paddr == `SFM_A_CTRL) && pwdata[`SFM_C_RESET];
            // A clearing write loses against an event in the same cycle.
            if (wr && (paddr == `SFM_A_STATUS)) begin
                status_r <= (status_r & ~pwdata[3:0]) | (ev & ~fault_bits_r);
            end else begin
                status_r <= status_r | (ev & ~fault_bits_r);
            end
            if (wr && (paddr == `SFM_A_MASK)) begin
                mask_r <= pwdata[3:0];
            end
            if (wr && (paddr == `SFM_A_CTRL)) begin
                ctrl_r <= pwdata[4:0];
            end
            if (wr && (paddr == `SFM_A_RFEN)) begin
                rf_en_r <= pwdata[NCH-1:0];
            end
        end
    end
    // Level interrupt: it stays high until software clears every unmasked bit.
    assign irq = |(status_r & mask_r);

    always @(posedge clk_sys) begin
        if (rst) begin
            prdata <= 32'h00000000;
        end else if (psel && !penable && !pwrite) begin
            case (paddr)
                `SFM_A_STATUS: prdata <= pad_flt(status_r);
                `SFM_A_MASK: prdata <= pad_flt(mask_r);
                `SFM_A_CTRL: prdata <= {27'h0000000, ctrl_r};
                `SFM_A_RFEN: prdata <= pad_ch(rf_en_r);
                `SFM_A_FAULT: prdata <= pad_flt(fault_bits_r);
                `SFM_A_RED: prdata <= pad_ch(red_led_r);
                `SFM_A_YEL: prdata <= pad_ch(yel_led_r);
                `SFM_A_GRN: prdata <= pad_ch(grn_led_r);
                `SFM_A_BOVAL: prdata <= bo_set ? `SFM_BO_ON_VAL : `SFM_BO_OFF_VAL;
                default: prdata <= 32'h00000000;
            endcase
        end
    end

endmodule // sfm_monitor
`default_nettype wire

/* verif/sfm_chk_monitor.sv */
// Port-level assertions of the signal fault monitor timing block.
`timescale 1ns/10ps
`default_nettype none
module sfm_chk #(parameter FLD_CYC = 20) (
    input wire logic clk_sys,
    input wire logic rst,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic pready,
    input wire logic pslverr,
    input wire logic [17:0] red_in,
    input wire logic red_interface_cable,
    input wire logic power_fail_in,
    input wire logic front_reset_in,
    input wire logic remote_reset_in,
    input wire logic fault_r,
    input wire logic flash_r,
    input wire logic [17:0] red_led_r
);
    logic [7:0] hi_cnt_r;
    logic [4:0] clr_r;
    wire clr_now = front_reset_in | remote_reset_in | power_fail_in
        | (psel & penable & pwrite & (paddr == 12'h008) & pwdata[5]);
    wire clr = clr_now | (|clr_r);
    // Clearing causes pass through synchronisers, so they are stretched here.
    always @(posedge clk_sys) begin
        clr_r <= {clr_r[3:0], clr_now};
        hi_cnt_r <= (rst | ~red_in[2]) ? 8'h00 : hi_cnt_r + {7'h00, hi_cnt_r != 8'hFF};
    end
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (rst);
    sequence s_cable_out;
        (!red_interface_cable && !clr) [*5];
    endsequence
    sequence s_red_dark;
        (!red_in[2] && !fault_r) [*6];
    endsequence
    AST_FLASH: assert property (flash_r == fault_r)
        else $error("flash and fault differ");
    AST_HOLD: assert property (fault_r && !clr |=> fault_r)
        else $error("fault dropped without a reset");
    AST_FREEZE: assert property (fault_r ##1 fault_r |-> $stable(red_led_r))
        else $error("indicators moved while fault held");
    AST_LEDON: assert property ($rose(red_led_r[2]) |-> hi_cnt_r >= FLD_CYC)
        else $error("red qualified too early");
    AST_LEDOFF: assert property (s_red_dark |-> !red_led_r[2])
        else $error("red indicator stuck on");
    AST_CABLE: assert property (s_cable_out |-> fault_r)
        else $error("cable removal not latched");
    AST_PSLV: assert property (pslverr |-> psel && penable)
        else $error("error outside access phase");
    AST_RDY: assert property (psel && penable |-> pready)
        else $error("access phase not answered");
endmodule // sfm_chk
`default_nettype wire

/* verif/sfm_field.sv */
// Field side model: lamp drives, red gate and controller watchdog.
`timescale 1ns/10ps
`default_nettype none
module sfm_field (
    input wire logic clk_sys,
    input wire logic wd_run,
    input wire logic [17:0] red_cmd,
    input wire logic [17:0] grn_cmd,
    output logic [17:0] red_in,
    output logic [17:0] yel_in,
    output logic [17:0] grn_in,
    output logic red_gate_in,
    output logic watchdog_in
);
    initial begin
        red_in = 18'h3FFFF;
        yel_in = 18'h00000;
        grn_in = 18'h00000;
        red_gate_in = 1'b1;
        watchdog_in = 1'b0;
    end
    // A stalled controller stops toggling; the line then simply holds.
    always @(posedge clk_sys) begin
        red_in <= red_cmd;
        grn_in <= grn_cmd;
        watchdog_in <= wd_run ? ~watchdog_in : watchdog_in;
    end
endmodule // sfm_field
`default_nettype wire

/* verif/sfm_monitor_tb.sv */
// Self-checking bench of the signal fault monitor timing block.
`timescale 1ns/10ps
`default_nettype none
module sfm_monitor_tb;
    localparam int RFL = 60;
    localparam int WDS = 50;
    localparam int FLD = 20;
    localparam int INH = 30;
    logic clk_sys = 1'b0;
    logic rst = 1'b1;
    logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0, rerr;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0, rdat;
    logic wd_run = 1'b1, inh1 = 1'b0, sense = 1'b0, cable = 1'b1, pfail = 1'b0, frst = 1'b0;
    logic [17:0] red_cmd = 18'h3FFFF, grn_cmd = 18'h0, red_in, yel_in, grn_in, rled, yled, gled;
    wire pready, pslverr, irq, fault_r, flash_r, act, gate, wdog;
    wire [31:0] prdata;
    int failures = 0, cmp_count = 0, wcnt, exp_flt, seed = 16;
    initial forever #12.5 clk_sys = ~clk_sys;
    sfm_field u_sfm_field (.clk_sys(clk_sys), .wd_run(wd_run), .red_cmd(red_cmd),
        .grn_cmd(grn_cmd), .red_in(red_in), .yel_in(yel_in), .grn_in(grn_in),
        .red_gate_in(gate), .watchdog_in(wdog));
    sfm_monitor #(.RF_LONG_CYC(RFL), .RF_SHORT_CYC(40), .WD_LONG_CYC(90), .WD_SHORT_CYC(WDS),
        .INH_CYC(INH), .FLD_CYC(FLD)) u_sfm_monitor (.clk_sys(clk_sys), .rst(rst), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready),
        .prdata(prdata), .pslverr(pslverr), .red_in(red_in), .yel_in(yel_in), .grn_in(grn_in),
        .inhibit1_in(inh1), .inhibit2_in(1'b0), .red_gate_in(gate), .relay_common_sense(sense),
        .red_interface_cable(cable), .watchdog_in(wdog), .power_fail_in(pfail),
        .front_reset_in(frst), .remote_reset_in(1'b0), .irq(irq), .fault_r(fault_r),
        .flash_r(flash_r), .relay_common_act_r(act), .red_led_r(rled), .yel_led_r(yled),
        .grn_led_r(gled));
    task automatic chk(input logic [31:0] s, input logic [31:0] e);
        cmp_count++;
        if (s !== e) begin
            failures++;
            $display("MISMATCH t=%0t seen=%h exp=%h", $time, s, e);
        end
    endtask
    task print_verdict;
        $display("comparisons %0d mismatches %0d", cmp_count, failures);
        if (failures == 0 && cmp_count > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask
    task automatic tick(input int n);
        repeat (n) @(posedge clk_sys);
    endtask
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        int n;
        n = 0;
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk_sys);
        penable <= 1'b1;
        do begin
            @(posedge clk_sys);
            n++;
        end while (pready !== 1'b1 && n < 20);
        rdat = prdata;
        rerr = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge clk_sys);
        if (n >= 20) begin
            failures++;
            print_verdict();
        end
    endtask
    task automatic rchk(input logic [11:0] a, input logic [31:0] e);
        apb(1'b0, a, 32'h0);
        chk(rdat, e);
    endtask
    // Counts edges until the fault latch sets; running out ends the run.
    task automatic wflt(input int lim);
        wcnt = 0;
        while (fault_r !== 1'b1 && wcnt < lim) begin
            @(posedge clk_sys);
            wcnt++;
        end
        if (wcnt >= lim) begin
            failures++;
            print_verdict();
        end
    endtask
    initial begin
        tick(12);
        rst <= 1'b0;
        tick(1);
        rchk(12'h008, 32'h3);
        rchk(12'h00C, 32'h3FFFF);
        rchk(12'h040, 32'h0);
        chk(rerr, 1'b1);
        tick(FLD + 8);
        rchk(12'h014, 32'h3FFFF);
        chk(yled, 18'h0);
        grn_cmd[1] <= 1'b1;
        tick(2 + ($random(seed) & 3));
        grn_cmd[1] <= 1'b0;
        tick(FLD + 8);
        rchk(12'h01C, 32'h0);
        grn_cmd[1] <= 1'b1;
        tick(FLD + 8);
        rchk(12'h01C, 32'h2);
        red_cmd[2] <= 1'b0;
        tick(20);
        red_cmd[2] <= 1'b1;
        tick(70);
        chk(fault_r, 1'b0);
        inh1 <= 1'b1;
        tick(INH + 8);
        red_cmd[2] <= 1'b0;
        tick(RFL + 20);
        chk(fault_r, 1'b0);
        inh1 <= 1'b0;
        wflt(RFL + 30);
        chk(wcnt >= RFL && wcnt <= RFL + 12, 1'b1);
        exp_flt = 1;
        rchk(12'h010, exp_flt);
        red_cmd[2] <= 1'b1;
        tick(FLD + 8);
        rchk(12'h014, 32'h3FFFB);
        chk(flash_r, 1'b1);
        apb(1'b1, 12'h004, 32'h1);
        chk(irq, 1'b1);
        apb(1'b1, 12'h000, 32'h1);
        chk(irq, 1'b0);
        frst <= 1'b1;
        tick(1);
        frst <= 1'b0;
        tick(6);
        chk(fault_r, 1'b0);
        rchk(12'h014, 32'h3FFFF);
        wd_run <= 1'b0;
        wflt(WDS + 20);
        chk(wcnt >= WDS - 2 && wcnt <= WDS + 8, 1'b1);
        exp_flt = 2;
        rchk(12'h010, exp_flt);
        wd_run <= 1'b1;
        pfail <= 1'b1;
        tick(2);
        pfail <= 1'b0;
        tick(6);
        apb(1'b0, 12'h010, 32'h0);
        chk(rdat[1], 1'b0);
        rchk(12'h020, 32'h0);
        apb(1'b1, 12'h008, 32'h7);
        rchk(12'h020, 32'h190);
        sense <= 1'b1;
        tick(5);
        chk(act, 1'b1);
        apb(1'b1, 12'h008, 32'h17);
        tick(3);
        chk(act, 1'b0);
        cable <= 1'b0;
        tick(6);
        chk(fault_r, 1'b1);
        apb(1'b0, 12'h010, 32'h0);
        chk(rdat[2], 1'b1);
        print_verdict();
    end
    initial begin
        tick(20000);
        failures++;
        print_verdict();
    end
endmodule // sfm_monitor_tb
bind sfm_monitor sfm_chk #(.FLD_CYC(FLD_CYC)) u_sfm_chk (.clk_sys(clk_sys), .rst(rst),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .pready(pready), .pslverr(pslverr), .red_in(red_in), .power_fail_in(power_fail_in),
    .red_interface_cable(red_interface_cable), .front_reset_in(front_reset_in),
    .remote_reset_in(remote_reset_in), .fault_r(fault_r), .flash_r(flash_r),
    .red_led_r(red_led_r));
`default_nettype wire
